// ---- elapsed_count_bits_pkg.sv ----
package elapsed_count_bits_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 32;
    localparam int COUNT_W  = 48;
    localparam int SLICES   = 3;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [31:0] COUNT_LOW_ADDR    = 32'h0B0000C0;
    localparam logic [31:0] COUNT_MID_ADDR    = 32'h0B0000C2;
    localparam logic [31:0] COUNT_HIGH_ADDR   = 32'h0B0000C4;
    localparam logic [31:0] COMPARE_LOW_ADDR  = 32'h0B0000C8;
    localparam logic [31:0] COMPARE_MID_ADDR  = 32'h0B0000CA;
    localparam logic [31:0] COMPARE_HIGH_ADDR = 32'h0B0000CC;
    localparam logic [31:0] EVENT_STATUS_ADDR = 32'h0B0000E0;
    localparam logic [31:0] EVENT_MASK_ADDR   = 32'h0B0000E2;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int ALARM_BIT                  = 0;
    localparam logic [15:0] REG_RESET         = 16'h0000;
    localparam logic [47:0] COUNT_RESET       = 48'h000000000000;
    localparam logic [47:0] COUNT_STEP        = 48'h000000000001;
    localparam logic [2:0]  ALL_SLICES        = 3'h7;
    localparam logic [2:0]  NO_SLICES         = 3'h0;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_FREQ_HZ      = 50000000;
    localparam int RTC_FREQ_MHZ_X1K = 32768;
    localparam int REWRITE_GAP_US   = 100;
    localparam int REWRITE_GAP_CYC  = (REWRITE_GAP_US * (CLK_FREQ_HZ / 1000000));

endpackage

// ---- slice_load_if.sv ----
`timescale 1ns/10ps
interface slice_load_if;
    logic [2:0]  wr_sel;
    logic [15:0] wr_data;
    logic        load;
    logic [47:0] value;

    modport ctrl  (output wr_sel, output wr_data, input load, input value);
    modport stage (input wr_sel, input wr_data, output load, output value);
endinterface

// ---- slice_stager.sv ----
`timescale 1ns/10ps
module slice_stager (
    input  wire logic   clk_in,
    input  wire logic   any_rst_in,
    slice_load_if.stage sl
);

    logic [47:0] hold_ff;
    logic [2:0]  seen_ff;
    logic [47:0] nxt_hold;
    logic [2:0]  nxt_seen;
    logic        all_seen;

    // ****************************************************************
    // slice gathering
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < elapsed_count_bits_pkg::SLICES; g++) begin : g_slice
            assign nxt_hold[g*elapsed_count_bits_pkg::DATA_W +: elapsed_count_bits_pkg::DATA_W] = sl.wr_sel[g] ?
                sl.wr_data : hold_ff[g*elapsed_count_bits_pkg::DATA_W +: elapsed_count_bits_pkg::DATA_W];
        end
    endgenerate

    // slices may arrive in any order; a repeated slice just overwrites
    assign all_seen = ((seen_ff | sl.wr_sel) == elapsed_count_bits_pkg::ALL_SLICES);
    assign nxt_seen = all_seen ? elapsed_count_bits_pkg::NO_SLICES : (seen_ff | sl.wr_sel);
    assign sl.load  = all_seen;
    assign sl.value = nxt_hold;

    always_ff @(posedge clk_in) begin
        if (any_rst_in) begin
            hold_ff <= elapsed_count_bits_pkg::COUNT_RESET;
            seen_ff <= elapsed_count_bits_pkg::NO_SLICES;
        end else begin
            hold_ff <= nxt_hold;
            seen_ff <= nxt_seen;
        end
    end

endmodule

// ---- elapsed_time_counter_alarm.sv ----
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - 48-bit counter steps once per rtc tick
// - count bits split low, mid, high slices
// - count equal compare raises alarm, keeps counting
// - count load after all three slices written
// - 48-bit compare in three read/write slices
// - compare changes only after all three slices
// - count reads are live, no snapshot
// - rtc reset zeroes compare, others keep it
// - count wraps to zero past maximum
module elapsed_time_counter_alarm (
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    input  wire logic        RTC_DOMAIN_RESET_IN,
    input  wire logic        RTC_CLK_IN,
    input  wire logic [31:0] ADDR_IN,
    input  wire logic [15:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [15:0] RDATA_OUT,
    output logic             ALARM_IRQ_OUT
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic        any_rst;
    logic        rtc_s1_ff;
    logic        rtc_s2_ff;
    logic        rtc_s3_ff;
    logic        rtc_level_ff;
    logic        rtc_agree;
    logic        rtc_tick;
    logic [47:0] count_ff;
    logic [47:0] nxt_count;
    logic [47:0] compare_ff;
    logic [47:0] nxt_compare;
    logic        match;
    logic        match_prev_ff;
    logic        alarm_event;
    logic        status_ff;
    logic        nxt_status;
    logic        mask_ff;
    logic        nxt_mask;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic [2:0]  count_hit;
    logic [2:0]  compare_hit;
    logic        status_hit;
    logic        mask_hit;
    logic [15:0] count_rd;
    logic [15:0] compare_rd;
    logic        status_clear;
    logic        status_wr;
    logic        mask_wr;
    logic [47:0] count_plus;
    logic [15:0] status_rd;
    logic [15:0] mask_rd;
    logic [15:0] slice_rd;

    slice_load_if count_sl ();
    slice_load_if compare_sl ();

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic [2:0] slice_hit(input logic [31:0] addr,
                                             input logic [31:0] lo,
                                             input logic [31:0] mid,
                                             input logic [31:0] hi);
        slice_hit = {addr == hi, addr == mid, addr == lo};
    endfunction

    function automatic logic [15:0] pick_slice(input logic [47:0] value,
                                               input logic [2:0]  hit);
        logic [15:0] word;
        word = elapsed_count_bits_pkg::REG_RESET;
        for (int s = 0; s < elapsed_count_bits_pkg::SLICES; s++) begin
            if (hit[s]) begin
                word = value[s*elapsed_count_bits_pkg::DATA_W +: elapsed_count_bits_pkg::DATA_W];
            end
        end
        return word;
    endfunction

    function automatic logic [15:0] flag_word(input logic flag);
        logic [15:0] word;
        word                       = elapsed_count_bits_pkg::REG_RESET;
        word[elapsed_count_bits_pkg::ALARM_BIT] = flag;
        return word;
    endfunction

    assign count_hit   = slice_hit(ADDR_IN, elapsed_count_bits_pkg::COUNT_LOW_ADDR,
                                   elapsed_count_bits_pkg::COUNT_MID_ADDR, elapsed_count_bits_pkg::COUNT_HIGH_ADDR);
    assign compare_hit = slice_hit(ADDR_IN, elapsed_count_bits_pkg::COMPARE_LOW_ADDR,
                                   elapsed_count_bits_pkg::COMPARE_MID_ADDR, elapsed_count_bits_pkg::COMPARE_HIGH_ADDR);
    assign status_hit  = (ADDR_IN == elapsed_count_bits_pkg::EVENT_STATUS_ADDR);
    assign mask_hit    = (ADDR_IN == elapsed_count_bits_pkg::EVENT_MASK_ADDR);

    // ****************************************************************
    // rtc clock pin sampling
    // ****************************************************************
    // the rtc clock is only sampled here; at 50 MHz each rtc phase spans
    // hundreds of cycles, so a three-stage chain whose last two stages must agree is ample
    assign rtc_agree = (rtc_s2_ff == rtc_s3_ff);
    assign rtc_tick  = rtc_agree && rtc_s3_ff && !rtc_level_ff;

    // no reset on the sampling chain: the system reset must not stall
    // time, so ticks keep landing while it is held
    always_ff @(posedge CLK_IN) begin
        rtc_s1_ff <= RTC_CLK_IN;
        rtc_s2_ff <= rtc_s1_ff;
        rtc_s3_ff <= rtc_s2_ff;
    end

    // follows the pin during the rtc reset, so a pin that is high at
    // release gives no false tick
    always_ff @(posedge CLK_IN) begin
        if (RTC_DOMAIN_RESET_IN) begin
            rtc_level_ff <= rtc_s3_ff;
        end else if (rtc_agree) begin
            rtc_level_ff <= rtc_s3_ff;
        end else begin
            rtc_level_ff <= rtc_level_ff;
        end
    end

    // ****************************************************************
    // slice staging
    // ****************************************************************
    assign any_rst            = SRST_IN || RTC_DOMAIN_RESET_IN;
    assign count_sl.wr_sel    = WR_IN ? count_hit : elapsed_count_bits_pkg::NO_SLICES;
    assign count_sl.wr_data   = WDATA_IN;
    assign compare_sl.wr_sel  = WR_IN ? compare_hit : elapsed_count_bits_pkg::NO_SLICES;
    assign compare_sl.wr_data = WDATA_IN;

    slice_stager u_count_stage (
        .clk_in     (CLK_IN),
        .any_rst_in (any_rst),
        .sl         (count_sl)
    );

    slice_stager u_compare_stage (
        .clk_in     (CLK_IN),
        .any_rst_in (any_rst),
        .sl         (compare_sl)
    );

    // ****************************************************************
    // counter and compare
    // ****************************************************************
    // a complete software load wins over a tick in the same cycle
    assign count_plus  = count_ff + elapsed_count_bits_pkg::COUNT_STEP;
    assign nxt_count   = count_sl.load ? count_sl.value :
                         rtc_tick      ? count_plus :
                         count_ff;
    assign nxt_compare = compare_sl.load ? compare_sl.value : compare_ff;

    // only the rtc reset touches these; the system reset lets time run on
    always_ff @(posedge CLK_IN) begin
        if (RTC_DOMAIN_RESET_IN) begin
            count_ff <= elapsed_count_bits_pkg::COUNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RTC_DOMAIN_RESET_IN) begin
            compare_ff <= elapsed_count_bits_pkg::COUNT_RESET;
        end else begin
            compare_ff <= nxt_compare;
        end
    end

    // ****************************************************************
    // alarm and interrupt
    // ****************************************************************
    // edge of equality, so one match gives one event though the value
    // stays equal for a whole rtc period
    assign match        = (count_ff == compare_ff);
    assign alarm_event  = match && !match_prev_ff;
    assign status_wr    = WR_IN && status_hit;
    assign mask_wr      = WR_IN && mask_hit;
    assign status_clear = status_wr && WDATA_IN[elapsed_count_bits_pkg::ALARM_BIT];
    // an alarm in the cycle of a clear wins, so no event is lost
    assign nxt_status   = alarm_event || (status_ff && !status_clear);
    assign nxt_mask     = mask_wr ? WDATA_IN[elapsed_count_bits_pkg::ALARM_BIT] : mask_ff;

    // starts as matching, so zero count against zero compare after a
    // reset raises no alarm
    always_ff @(posedge CLK_IN) begin
        if (any_rst) begin
            match_prev_ff <= 1'b1;
        end else begin
            match_prev_ff <= match;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (any_rst) begin
            status_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (any_rst) begin
            mask_ff <= 1'b0;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    assign ALARM_IRQ_OUT = status_ff && mask_ff;

    // ****************************************************************
    // read path
    // ****************************************************************
    // no snapshot: a read of any slice sees the count as it is now
    assign count_rd   = pick_slice(count_ff, count_hit);
    assign compare_rd = pick_slice(compare_ff, compare_hit);
    assign status_rd  = flag_word(status_ff);
    assign mask_rd    = flag_word(mask_ff);
    assign slice_rd   = count_rd | compare_rd;
    assign nxt_rdata  = !RD_IN     ? elapsed_count_bits_pkg::REG_RESET :
                        status_hit ? status_rd :
                        mask_hit   ? mask_rd :
                        slice_rd;

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            rdata_ff <= elapsed_count_bits_pkg::REG_RESET;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA_OUT = rdata_ff;

endmodule

// ---- rtc_osc_model.sv ----
`timescale 1ns/10ps
module rtc_osc_model #(
    parameter int HALF_NS = 15259
) (
    output logic rtc_clk_out
);
    // a crystal runs free, so it keeps toggling between bus accesses
    initial rtc_clk_out = 1'b0;
    always #(HALF_NS) rtc_clk_out = ~rtc_clk_out;
endmodule

// ---- elapsed_time_counter_alarm_assertions.sv ----
`timescale 1ns/10ps
module elapsed_time_counter_alarm_assertions (
    input wire logic        CLK_IN,
    input wire logic        SRST_IN,
    input wire logic        RTC_DOMAIN_RESET_IN,
    input wire logic        RTC_CLK_IN,
    input wire logic [31:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic        WR_IN,
    input wire logic        RD_IN,
    input wire logic [15:0] RDATA_OUT,
    input wire logic        ALARM_IRQ_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN || RTC_DOMAIN_RESET_IN);
    sequence lo_rd;
        RD_IN && ADDR_IN == elapsed_count_bits_pkg::COUNT_LOW_ADDR;
    endsequence
    rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
        else $error("read data outside read slot");
    unmapped_read_a: assert property (RD_IN && ADDR_IN == 32'h0B0000C6 |=> RDATA_OUT == 16'h0000)
        else $error("unmapped read not zero");
    mask_off_a: assert property (WR_IN && ADDR_IN == elapsed_count_bits_pkg::EVENT_MASK_ADDR && !WDATA_IN[0] |=> !ALARM_IRQ_OUT)
        else $error("masked alarm still high");
    srst_quiet_a: assert property ($fell(SRST_IN) |-> RDATA_OUT == 16'h0000 && !ALARM_IRQ_OUT)
        else $error("outputs busy after reset");
    rtc_quiet_a: assert property ($fell(RTC_DOMAIN_RESET_IN) |-> !ALARM_IRQ_OUT)
        else $error("alarm high after rtc reset");
    status_seen_a: assert property (RD_IN && ADDR_IN == elapsed_count_bits_pkg::EVENT_STATUS_ADDR && ALARM_IRQ_OUT |=> RDATA_OUT[0])
        else $error("status bit clear while alarm high");
    irq_hold_a: assert property (ALARM_IRQ_OUT && !WR_IN |=> ALARM_IRQ_OUT)
        else $error("alarm dropped without a write");
    count_step_a: assert property (lo_rd ##2 lo_rd |=> (RDATA_OUT - $past(RDATA_OUT, 2)) <= 16'h0001)
        else $error("count low jumped by more than one");
endmodule
bind elapsed_time_counter_alarm elapsed_time_counter_alarm_assertions u_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
    .RTC_DOMAIN_RESET_IN(RTC_DOMAIN_RESET_IN), .RTC_CLK_IN(RTC_CLK_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .ALARM_IRQ_OUT(ALARM_IRQ_OUT));

// ---- elapsed_time_counter_alarm_tb_top.sv ----
`timescale 1ns/10ps
module elapsed_time_counter_alarm_tb_top;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        rtc_rst = 1'b1;
    logic        rtc_clk;
    logic [31:0] addr = 32'h00000000;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        irq;
    integer      seed = 57171;
    integer      mismatches = 0;
    integer      comparisons = 0;
    logic [47:0] v;
    logic [47:0] got;
    logic [15:0] r16;
    always #10 clk = ~clk;
    rtc_osc_model u_osc (.rtc_clk_out(rtc_clk));
    elapsed_time_counter_alarm u_dut (.CLK_IN(clk), .SRST_IN(srst), .RTC_DOMAIN_RESET_IN(rtc_rst),
        .RTC_CLK_IN(rtc_clk), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .ALARM_IRQ_OUT(irq));
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [47:0] rnd48();
        logic [31:0] x;
        logic [31:0] y;
        x = $random(seed);
        y = $random(seed);
        return {x[15:0], y};
    endfunction
    function automatic logic [47:0] nxt(input logic [47:0] c);
        return c + 48'h000000000001;
    endfunction
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr16(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd16(input logic [31:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wr48(input logic [31:0] a, input logic [47:0] d);
        wr16(a, d[15:0]);
        wr16(a + 32'h2, d[31:16]);
        wr16(a + 32'h4, d[47:32]);
    endtask
    // slices are not latched, so read twice until two passes agree
    task automatic rd48(input logic [31:0] a, output logic [47:0] d);
        logic [47:0] p;
        logic [47:0] q;
        p = 48'h000000000000;
        q = 48'h000000000001;
        for (int i = 0; i < 4 && p !== q; i++) begin
            rd16(a, p[15:0]);
            rd16(a + 32'h2, p[31:16]);
            rd16(a + 32'h4, p[47:32]);
            rd16(a, q[15:0]);
            rd16(a + 32'h2, q[31:16]);
            rd16(a + 32'h4, q[47:32]);
        end
        if (p !== q) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t slice reads never agreed", $time);
            finish_test();
        end
        d = q;
    endtask
    task automatic wait_tick(input logic [15:0] old);
        logic [15:0] cur;
        cur = old;
        for (int i = 0; i < 2000 && cur === old; i++) begin
            rd16(elapsed_count_bits_pkg::COUNT_LOW_ADDR, cur);
        end
        if (cur === old) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t no tick seen", $time);
            finish_test();
        end
    endtask
    task automatic gap;
        repeat (elapsed_count_bits_pkg::REWRITE_GAP_CYC) @(posedge clk);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rtc_rst <= 1'b0;
        rd48(elapsed_count_bits_pkg::COMPARE_LOW_ADDR, got);
        check(got, 48'h000000000000);
        rd48(elapsed_count_bits_pkg::COUNT_LOW_ADDR, got);
        check({got[47:16], 16'h0000}, 48'h000000000000);
        v = rnd48();
        wr16(elapsed_count_bits_pkg::COMPARE_LOW_ADDR, v[15:0]);
        wr16(elapsed_count_bits_pkg::COMPARE_MID_ADDR, v[31:16]);
        rd48(elapsed_count_bits_pkg::COMPARE_LOW_ADDR, got);
        check(got, 48'h000000000000);
        wr16(elapsed_count_bits_pkg::COMPARE_HIGH_ADDR, v[47:32]);
        rd48(elapsed_count_bits_pkg::COMPARE_LOW_ADDR, got);
        check(got, v);
        r16 = 16'h0000;
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? {rnd48() | 48'h000000001234} & 48'hFFFFFFFF7FFF : 48'hFFFFFFFFFFFF;
            wr16(elapsed_count_bits_pkg::COUNT_LOW_ADDR, v[15:0]);
            wr16(elapsed_count_bits_pkg::COUNT_MID_ADDR, v[31:16]);
            rd16(elapsed_count_bits_pkg::COUNT_HIGH_ADDR, got[15:0]);
            check({32'h00000000, got[15:0]}, {32'h00000000, r16});
            r16 = v[47:32];
            wr16(elapsed_count_bits_pkg::COUNT_HIGH_ADDR, v[47:32]);
            rd48(elapsed_count_bits_pkg::COUNT_LOW_ADDR, got);
            check((got === nxt(v)) ? v : got, v);
            if (got === v) wait_tick(v[15:0]);
            rd48(elapsed_count_bits_pkg::COUNT_LOW_ADDR, got);
            check(got, nxt(v));
            gap();
        end
        got = rnd48();
        v = {got[47:16], 16'h0100};
        wr16(elapsed_count_bits_pkg::EVENT_MASK_ADDR, 16'h0001);
        wr48(elapsed_count_bits_pkg::COMPARE_LOW_ADDR, nxt(v));
        wr48(elapsed_count_bits_pkg::COUNT_LOW_ADDR, v);
        #1 check({47'h0, irq}, 48'h000000000000);
        for (int i = 0; i < 4000 && irq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check({47'h0, irq}, 48'h000000000001);
        if (irq !== 1'b1) finish_test();
        rd48(elapsed_count_bits_pkg::COUNT_LOW_ADDR, got);
        if (got === nxt(v)) wait_tick(got[15:0]);
        rd48(elapsed_count_bits_pkg::COUNT_LOW_ADDR, got);
        check(got, nxt(nxt(v)));
        rd16(elapsed_count_bits_pkg::EVENT_STATUS_ADDR, r16);
        check({32'h00000000, r16}, 48'h000000000001);
        rd16(32'h0B0000C6, r16);
        check({32'h00000000, r16}, 48'h000000000000);
        wr16(elapsed_count_bits_pkg::EVENT_MASK_ADDR, 16'h0000);
        #1 check({47'h0, irq}, 48'h000000000000);
        wr16(elapsed_count_bits_pkg::EVENT_MASK_ADDR, 16'h0001);
        #1 check({47'h0, irq}, 48'h000000000001);
        wr16(elapsed_count_bits_pkg::EVENT_STATUS_ADDR, 16'h0001);
        #1 check({47'h0, irq}, 48'h000000000000);
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd48(elapsed_count_bits_pkg::COMPARE_LOW_ADDR, got);
        check(got, nxt(v));
        rd48(elapsed_count_bits_pkg::COUNT_LOW_ADDR, got);
        check({got[47:16], 16'h0000}, {v[47:16], 16'h0000});
        @(posedge clk);
        rtc_rst <= 1'b1;
        repeat (3) @(posedge clk);
        rtc_rst <= 1'b0;
        rd48(elapsed_count_bits_pkg::COMPARE_LOW_ADDR, got);
        check(got, 48'h000000000000);
        rd48(elapsed_count_bits_pkg::COUNT_LOW_ADDR, got);
        check({got[47:16], 16'h0000}, 48'h000000000000);
        finish_test();
    end
endmodule
